/* File: rtl/fail_safe_supervisor.sv */
// Contract
// - Module presence faults are minor, always checked
// - Any major fault enters fail-safe
// - Fail-safe forces all relays idle
// - Fail-safe inhibits all protection
// - Fail-safe drives watchdog idle
// - Fail-safe lights red LED, requests diagnostic
// - Minor fault: downgraded, flagged, protection runs
// - Fail-safe entry starts restart with retest
// - Fault persists at restart: locked until power
// - Fault gone: resume, hold 5 to 7 s
// - Count each transient failure
// - Fifth transient locks, no restart
// - Counter cleared only by power-on reset
// - Alarm LED flashes on internal failure
`default_nettype none
module fail_safe_supervisor
#(
  parameter int unsigned TICK_DIV = fss_pkg::TICK_CYCLES
)
(
  input  wire logic                         mclk,
  input  wire logic                         resetn,
  input  wire logic [fss_pkg::N_MAJOR-1:0]  major_fail,
  input  wire logic [fss_pkg::N_MINOR-1:0]  module_absent,
  input  wire logic [fss_pkg::N_RELAY-1:0]  relay_request,
  output var  logic [fss_pkg::N_RELAY-1:0]  relay_drive,
  output var  logic                         protection_enable,
  output var  logic                         watchdog_out,
  output var  logic                         alarm_led,
  output var  logic                         diag_request,
  output var  logic [fss_pkg::N_MINOR-1:0]  minor_status,
  output var  logic                         downgraded,
  output var  logic                         retest_run,
  output var  logic [2:0]                   transient_count,
  output var  logic                         locked
);
  import fss_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [N_MAJOR-1:0] maj_s1_reg;
  logic [N_MAJOR-1:0] maj_s2_reg;
  logic [N_MINOR-1:0] min_s1_reg;
  logic [N_MINOR-1:0] min_s2_reg;

  always_ff @(posedge mclk)
  begin
    maj_s1_reg <= major_fail;
    maj_s2_reg <= maj_s1_reg;
    min_s1_reg <= module_absent;
    min_s2_reg <= min_s1_reg;
  end

  fss_timer_if tmr ();

  fss_tick_gen #(
    .TICK_DIV (TICK_DIV)
  ) u_tick (
    .mclk   (mclk),
    .resetn (resetn),
    .tmr    (tmr)
  );

  // ----------------------------------------
  // Classification
  // ----------------------------------------
  // Presence checks never reach the major path, so they cannot stop protection
  wire any_major = |maj_s2_reg;
  wire any_minor = |min_s2_reg;

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  sup_state_t  state_reg;
  sup_state_t  state_next;
  logic [12:0] ms_reg;
  logic [12:0] ms_next;
  logic        seen_reg;
  logic        seen_next;
  logic [2:0]  trans_reg;
  logic [2:0]  trans_next;
  logic        diag_reg;

  wire in_failsafe  = (state_reg == ST_RESTARTING) || (state_reg == ST_LOCKED);
  wire retest_phase = (state_reg == ST_RESTARTING) && (ms_reg < 13'(RETEST_MS));
  wire retest_end   = retest_phase && tmr.tick && (ms_reg == 13'(RETEST_MS - 1));
  wire hold_done    = (state_reg == ST_RESTARTING) && tmr.tick && (ms_reg == 13'(HOLD_MS - 1));
  wire transient_ok = hold_done && !seen_reg && !any_major;
  wire limit_hit    = transient_ok && (trans_reg == TRANSIENT_LIMIT - 3'h1);

  always_comb
  begin
    state_next = state_reg;
    ms_next    = ms_reg;
    seen_next  = seen_reg;
    trans_next = trans_reg;
    unique case (state_reg)
      ST_NORMAL, ST_DOWNGRADED:
      begin
        if (any_major)
        begin
          state_next = ST_RESTARTING;
          ms_next    = 13'h0;
          seen_next  = 1'b0;
        end
        else
          state_next = any_minor ? ST_DOWNGRADED : ST_NORMAL;
      end
      ST_RESTARTING:
      begin
        if (tmr.tick)
          ms_next = ms_reg + 13'h1;
        // Verdict taken as the rerun window closes; by then the entry fault has long left the two-stage syncs
        if (retest_end && any_major)
          seen_next = 1'b1;
        if (hold_done)
        begin
          if (seen_reg || any_major)
            state_next = ST_LOCKED;
          else if (limit_hit)
          begin
            trans_next = trans_reg + 3'h1;
            state_next = ST_LOCKED;
          end
          else
          begin
            trans_next = trans_reg + 3'h1;
            state_next = ST_NORMAL;
          end
        end
      end
      ST_LOCKED:
        state_next = ST_LOCKED;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state_reg <= ST_NORMAL;
      ms_reg    <= 13'h0;
      seen_reg  <= 1'b0;
      trans_reg <= TRANSIENT_RESET;
      diag_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ms_reg    <= ms_next;
      seen_reg  <= seen_next;
      trans_reg <= trans_next;
      diag_reg  <= (state_next == ST_RESTARTING) && !in_failsafe;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      relay_drive       <= '0;
      protection_enable <= 1'b0;
      watchdog_out      <= 1'b0;
      alarm_led         <= 1'b0;
      minor_status      <= '0;
    end
    else
    begin
      relay_drive       <= in_failsafe ? '0 : relay_request;
      protection_enable <= !in_failsafe;
      watchdog_out      <= !in_failsafe && !any_major;
      alarm_led         <= in_failsafe && tmr.blink;
      minor_status      <= min_s2_reg;
    end
  end

  assign diag_request    = diag_reg;
  assign downgraded      = (state_reg == ST_DOWNGRADED);
  assign retest_run      = retest_phase;
  assign transient_count = trans_reg;
  assign locked          = (state_reg == ST_LOCKED);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_major_seen;
    any_major && !in_failsafe;
  endsequence

  sequence s_transient_end;
    transient_ok && !limit_hit;
  endsequence

  chk_major_enters_safe: assert property (@(posedge mclk) disable iff (!resetn)
    s_major_seen |=> state_reg == ST_RESTARTING)
    else $error("major fault did not enter fail-safe");

  chk_relays_idle: assert property (@(posedge mclk) disable iff (!resetn)
    in_failsafe |=> relay_drive == '0)
    else $error("relay driven in fail-safe");

  chk_protect_inhibit: assert property (@(posedge mclk) disable iff (!resetn)
    in_failsafe |=> !protection_enable)
    else $error("protection not inhibited");

  chk_watchdog_idle: assert property (@(posedge mclk) disable iff (!resetn)
    in_failsafe |=> !watchdog_out)
    else $error("watchdog active in fail-safe");

  chk_diag_pulse: assert property (@(posedge mclk) disable iff (!resetn)
    s_major_seen |=> diag_request ##1 !diag_request)
    else $error("diagnostic request missing");

  chk_minor_downgrade: assert property (@(posedge mclk) disable iff (!resetn)
    (state_reg == ST_NORMAL && any_minor && !any_major) |=> downgraded ##1 protection_enable)
    else $error("minor fault not downgraded");

  chk_permanent_lock: assert property (@(posedge mclk) disable iff (!resetn)
    (hold_done && seen_reg) |=> locked)
    else $error("permanent fault not locked");

  chk_transient_resume: assert property (@(posedge mclk) disable iff (!resetn)
    s_transient_end |=> state_reg == ST_NORMAL && transient_count == $past(trans_reg) + 3'h1)
    else $error("transient not resumed");

  chk_fifth_locks: assert property (@(posedge mclk) disable iff (!resetn)
    limit_hit |=> locked && transient_count == TRANSIENT_LIMIT)
    else $error("fifth transient not locked");

  chk_lock_holds: assert property (@(posedge mclk) disable iff (!resetn)
    locked |=> locked [*2])
    else $error("locked state left");

  chk_healthy_wdog: assert property (@(posedge mclk) disable iff (!resetn)
    (!in_failsafe && !any_major) |=> watchdog_out)
    else $error("watchdog idle while healthy");
endmodule : fail_safe_supervisor
`default_nettype wire

/* File: rtl/fss_pkg.sv */
`default_nettype none
package fss_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned FAILSAFE_MIN_S  = 5;
  localparam int unsigned FAILSAFE_MAX_S  = 7;
  localparam int unsigned TICK_HZ         = 1000;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / TICK_HZ;
  // Hold time aims at the middle of the 5..7 s window
  localparam int unsigned HOLD_MS         = (FAILSAFE_MIN_S + FAILSAFE_MAX_S) * 1000 / 2;
  localparam int unsigned BLINK_MS        = 250;
  localparam int unsigned RETEST_MS       = 100;
  // ----------------------------------------
  // Counts and widths
  // ----------------------------------------
  localparam int unsigned N_RELAY         = 4;
  localparam int unsigned N_MINOR         = 3;
  localparam int unsigned N_MAJOR         = 8;
  localparam logic [2:0]  TRANSIENT_LIMIT = 3'h5;
  localparam logic [2:0]  TRANSIENT_RESET = 3'h0;

  typedef enum logic [1:0] {
    ST_NORMAL,
    ST_DOWNGRADED,
    ST_RESTARTING,
    ST_LOCKED
  } sup_state_t;
endpackage : fss_pkg
`default_nettype wire

/* File: rtl/fss_tick_gen.sv */
`default_nettype none
module fss_tick_gen
#(
  parameter int unsigned TICK_DIV = fss_pkg::TICK_CYCLES
)
(
  input  wire logic mclk,
  input  wire logic resetn,
  fss_timer_if.src  tmr
);
  import fss_pkg::*;

  // ----------------------------------------
  // Millisecond enable and alarm blink
  // ----------------------------------------
  logic [31:0] div_reg;
  logic [15:0] blink_cnt_reg;
  logic        tick_reg;
  logic        blink_reg;
  wire         div_wrap = (div_reg == 32'(TICK_DIV - 1));
  wire         blink_wrap = (blink_cnt_reg == 16'(BLINK_MS - 1));

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      div_reg       <= 32'h0;
      tick_reg      <= 1'b0;
      blink_cnt_reg <= 16'h0;
      blink_reg     <= 1'b0;
    end
    else
    begin
      div_reg  <= div_wrap ? 32'h0 : div_reg + 32'h1;
      tick_reg <= div_wrap;
      if (tick_reg)
      begin
        blink_cnt_reg <= blink_wrap ? 16'h0 : blink_cnt_reg + 16'h1;
        if (blink_wrap)
          blink_reg <= ~blink_reg;
      end
    end
  end

  assign tmr.tick  = tick_reg;
  assign tmr.blink = blink_reg;
endmodule : fss_tick_gen
`default_nettype wire

/* File: rtl/fss_timer_if.sv */
`default_nettype none
interface fss_timer_if;
  logic tick;
  logic blink;
  modport src (output tick, output blink);
  modport dst (input tick, input blink);
endinterface : fss_timer_if
`default_nettype wire

/* File: testbench/fail_safe_supervisor_tb.sv */
`default_nettype none
module fail_safe_supervisor_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import fss_pkg::*;
  // Short tick keeps the 6 s hold near 12000 cycles
  localparam int unsigned TD = 2;
  logic                 mclk;
  logic                 resetn;
  logic [N_MAJOR-1:0]   major_fail;
  logic [N_MINOR-1:0]   module_absent;
  logic [N_RELAY-1:0]   relay_request;
  logic [N_RELAY-1:0]   relay_drive;
  logic                 protection_enable;
  logic                 watchdog_out;
  logic                 alarm_led;
  logic                 diag_request;
  logic [N_MINOR-1:0]   minor_status;
  logic                 downgraded;
  logic                 retest_run;
  logic [2:0]           transient_count;
  logic                 locked;
  int                   errors;
  int                   n_tests;

  fss_monitor_model mon (.mclk(mclk), .major_fail(major_fail), .module_absent(module_absent),
    .relay_request(relay_request));
  fail_safe_supervisor #(.TICK_DIV(TD)) uut (.mclk(mclk), .resetn(resetn), .major_fail(major_fail),
    .module_absent(module_absent), .relay_request(relay_request), .relay_drive(relay_drive),
    .protection_enable(protection_enable), .watchdog_out(watchdog_out), .alarm_led(alarm_led),
    .diag_request(diag_request), .minor_status(minor_status), .downgraded(downgraded),
    .retest_run(retest_run), .transient_count(transient_count), .locked(locked));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task end_of_test;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task do_reset;
    resetn = 1'b0;
    repeat (6) @(negedge mclk);
    resetn = 1'b1;
    repeat (2) @(negedge mclk);
    chk({watchdog_out, protection_enable}, 8'h03);
    chk({locked, transient_count}, 8'h00);
  endtask : do_reset

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task minor_faults;
    for (int i = 0; i < N_MINOR; i++)
    begin
      mon.set_minor(3'h1 << i);
      mon.set_relay(4'ha ^ 4'(i));
      repeat (5) @(negedge mclk);
      chk(minor_status, 8'(3'h1 << i));
      chk({downgraded, protection_enable, watchdog_out}, 8'h07);
      chk(relay_drive, 8'(4'ha ^ 4'(i)));
    end
    mon.set_minor(3'h0);
    repeat (5) @(negedge mclk);
    chk(downgraded, 8'h00);
  endtask : minor_faults

  task transient(input int k);
    int n;
    logic [1:0] led_seen;
    led_seen = 2'b00;
    n = 0;
    mon.set_relay(4'hf);
    mon.set_major(8'h1 << k);
    while (diag_request !== 1'b1 && n < 20)
    begin
      @(negedge mclk);
      n++;
    end
    chk(diag_request, 8'h01);
    repeat (2) @(negedge mclk);
    chk({relay_drive, protection_enable, watchdog_out}, 8'h00);
    chk({diag_request, retest_run}, 8'h01);
    mon.set_major(8'h00);
    n = 0;
    while (protection_enable !== 1'b1 && n < 16000)
    begin
      // Both levels must show: a steady lamp is no flash
      if (alarm_led === 1'b1)
        led_seen[0] = 1'b1;
      if (alarm_led === 1'b0)
        led_seen[1] = 1'b1;
      @(negedge mclk);
      n++;
    end
    chk(led_seen, 8'h03);
    if (k == 4)
      chk({locked, protection_enable}, 8'h02);
    else
      chk(n >= 5000 * TD && n <= 7000 * TD, 8'h01);
    chk(transient_count, 8'(k + 1));
  endtask : transient

  task permanent;
    mon.set_major(8'h80);
    repeat (1000) @(negedge mclk);
    chk({locked, protection_enable, retest_run}, 8'h00);
    mon.set_major(8'h00);
    // Lock is only decided when the whole hold has run out
    repeat (12000) @(negedge mclk);
    chk({locked, protection_enable, watchdog_out}, 8'h04);
  endtask : permanent

  initial
  begin
    errors = 0;
    n_tests = 0;
    do_reset();
    minor_faults();
    for (int k = 0; k < 5; k++)
      transient(k);
    do_reset();
    permanent();
    do_reset();
    end_of_test();
  end

  // Whole run is near 77000 cycles
  initial
  begin
    #2_500_000;
    errors++;
    end_of_test();
  end
endmodule : fail_safe_supervisor_tb
`default_nettype wire

/* File: testbench/fss_monitor_model.sv */
`default_nettype none
module fss_monitor_model
(
  input  wire logic                         mclk,
  output var  logic [fss_pkg::N_MAJOR-1:0]  major_fail,
  output var  logic [fss_pkg::N_MINOR-1:0]  module_absent,
  output var  logic [fss_pkg::N_RELAY-1:0]  relay_request
);
  timeunit 1ns;
  timeprecision 100ps;
  import fss_pkg::*;
  // ----------------------------------------
  // Monitor levels, changed only after a falling edge
  // ----------------------------------------
  initial
  begin
    major_fail    = '0;
    module_absent = '0;
    relay_request = '0;
  end

  task set_major(input logic [N_MAJOR-1:0] v);
    major_fail = v;
  endtask : set_major

  // Presence monitors report at any time, not only at start-up
  task set_minor(input logic [N_MINOR-1:0] v);
    module_absent = v;
  endtask : set_minor

  task set_relay(input logic [N_RELAY-1:0] v);
    relay_request = v;
  endtask : set_relay
endmodule : fss_monitor_model
`default_nettype wire
